// *** pkg/sdcap_pkg.sv ***
// Constants and types for the SDRAM column-access and concurrent auto precharge slice
//==============================================================================
// Operation
// [RULE1] Write burst mode bit set to one in mode register selects burst read/single write.
// [RULE2] In that mode every WRITE is a burst of one, whatever length is programmed.
// [RULE3] READ follows programmed burst length and sequence in both write burst modes.
// [RULE4] READ or WRITE to another bank is accepted during an auto precharge access.
// [RULE5] READ to another bank cuts an auto precharge READ one CAS latency later.
// [RULE6] That interrupted bank starts precharge when the interrupting READ is registered.
// [RULE7] WRITE to another bank ends auto precharge READ at once; precharge starts then.
// [RULE8] Controller raises data mask two clocks before such a WRITE to avoid contention.
// [RULE9] READ ends an auto precharge WRITE when registered; data out one CAS latency later.
// [RULE10] Then write recovery starts at the READ; precharge follows once recovery elapses.
// [RULE11] Last element written is the one a clock before the READ; later input dropped.
// [RULE12] WRITE interrupting auto precharge WRITE starts write recovery; precharge after it.
// [RULE13] Last element kept is the one registered a clock before the interrupting WRITE.
// [RULE14] Auto precharge closes the accessed row once its burst completes.
// [RULE15] Each bank keeps pending auto precharge state and a write recovery counter.
package sdcap_pkg;
   //==========================================================================
   // Command codes on {ras_n, cas_n, we_n}
   localparam logic [2:0] CMD_LMR = 3'h0;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR  = 3'h4;
   localparam logic [2:0] CMD_RD  = 3'h5;
   localparam logic [2:0] CMD_BST = 3'h6;
   //==========================================================================
   // Mode register fields and address bit positions
   localparam int MR_BL_LSB  = 0;
   localparam int MR_SEQ_BIT = 3;
   localparam int MR_CL_LSB  = 4;
   localparam int MR_WBM_BIT = 9;
   localparam int AP_BIT     = 10;
   localparam logic [2:0] MR_BL_RST = 3'h0;
   localparam logic [2:0] MR_CL_RST = 3'h2;
   localparam logic [2:0] BL_FULL   = 3'h7;
   //==========================================================================
   // Timing, printed figures and derived cycle counts
   localparam int CLK_NS  = 50;
   localparam int TWR_NS  = 15;
   localparam int TRP_NS  = 15;
   localparam int TWR_CYC = ((TWR_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
                            : (TWR_NS + CLK_NS - 1) / CLK_NS;
   localparam int TRP_CYC = ((TRP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1
                            : (TRP_NS + CLK_NS - 1) / CLK_NS;
   //==========================================================================
   // State types
   typedef enum logic [2:0] {BK_IDLE, BK_OPEN, BK_OPEN_AP, BK_RECOVER, BK_PRECHARGE}
      sdcap_bank_state_t;
   typedef enum logic [1:0] {BURST_IDLE, BURST_RD, BURST_WR} sdcap_burst_t;
endpackage

// *** pkg/sdcap_bank_if.sv ***
// Per-bank control bundle between the column engine and a bank tracker
`timescale 1ns/1ns
interface sdcap_bank_if #(parameter int ROW_W = 12);
   logic             activate;
   logic             precharge;
   logic             arm_ap;
   logic             end_rd;
   logic             end_wr;
   logic [ROW_W-1:0] row_in;
   logic             is_open;
   logic             busy;
   logic [ROW_W-1:0] row;
   modport bank (input activate, precharge, arm_ap, end_rd, end_wr, row_in,
                 output is_open, busy, row);
   modport core (output activate, precharge, arm_ap, end_rd, end_wr, row_in,
                 input is_open, busy, row);
endinterface

// *** rtl/sdcap_bank.sv ***
// One bank: open row, pending auto precharge, write recovery and precharge timing
`timescale 1ns/1ns
module sdcap_bank (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Control from the column engine
   sdcap_bank_if.bank bk
);
   sdcap_pkg::sdcap_bank_state_t state_reg, state_next;
   logic [3:0]                   cnt_reg,   cnt_next;
   logic [$bits(bk.row)-1:0]     row_reg,   row_next;
   logic                         ap_eff;

   //==========================================================================
   // Next state; an access armed and ended in one cycle (burst of one) still precharges
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      row_next   = row_reg;
      ap_eff     = bk.arm_ap || (state_reg == sdcap_pkg::BK_OPEN_AP); // RULE15
      unique case (state_reg)
         sdcap_pkg::BK_IDLE: begin
            if (bk.activate) begin
               state_next = sdcap_pkg::BK_OPEN;
               row_next   = bk.row_in;
            end
         end
         sdcap_pkg::BK_OPEN, sdcap_pkg::BK_OPEN_AP: begin
            if (ap_eff && bk.end_rd) begin
               state_next = sdcap_pkg::BK_PRECHARGE; // RULE6 RULE7 RULE14
               cnt_next   = 4'(sdcap_pkg::TRP_CYC - 1);
            end else if (ap_eff && bk.end_wr) begin
               state_next = sdcap_pkg::BK_RECOVER; // RULE10 RULE12 RULE14
               cnt_next   = 4'(sdcap_pkg::TWR_CYC - 1);
            end else if (bk.precharge && !ap_eff) begin
               state_next = sdcap_pkg::BK_PRECHARGE;
               cnt_next   = 4'(sdcap_pkg::TRP_CYC - 1);
            end else if (ap_eff) begin
               state_next = sdcap_pkg::BK_OPEN_AP; // RULE15
            end
         end
         sdcap_pkg::BK_RECOVER: begin
            if (cnt_reg == 4'h0) begin
               state_next = sdcap_pkg::BK_PRECHARGE; // RULE10 RULE12
               cnt_next   = 4'(sdcap_pkg::TRP_CYC - 1);
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         sdcap_pkg::BK_PRECHARGE: begin
            if (cnt_reg == 4'h0) begin
               state_next = sdcap_pkg::BK_IDLE;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         default: state_next = sdcap_pkg::BK_IDLE;
      endcase
   end

   //==========================================================================
   // State registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= sdcap_pkg::BK_IDLE;
         cnt_reg   <= 4'h0;
         row_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         row_reg   <= row_next;
      end
   end

   assign bk.is_open = (state_reg == sdcap_pkg::BK_OPEN) || (state_reg == sdcap_pkg::BK_OPEN_AP);
   assign bk.busy    = (state_reg != sdcap_pkg::BK_IDLE);
   assign bk.row     = row_reg;

   //==========================================================================
   // Checks
   a_ap_read_pre: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE6
      (bk.is_open && ap_eff && bk.end_rd) |=> state_reg == sdcap_pkg::BK_PRECHARGE)
      else $error("auto precharge read did not start precharge");
   a_ap_write_rec: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE10
      (bk.is_open && ap_eff && bk.end_wr) |=>
         (state_reg == sdcap_pkg::BK_RECOVER && cnt_reg == 4'(sdcap_pkg::TWR_CYC - 1))
         ##1 (cnt_reg != 4'h0 || state_reg == sdcap_pkg::BK_PRECHARGE))
      else $error("write recovery not timed before precharge");
endmodule // sdcap_bank

// *** rtl/sdcap_core.sv ***
// SDRAM column engine: mode register, bursts, interruption and read data path
`timescale 1ns/1ns
module sdcap_core #(
   parameter int DATA_W = 16,
   parameter int ROW_W  = 12,
   parameter int COL_W  = 8
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   // Command and address from the controller
   input  wire logic              cs_n,
   input  wire logic              ras_n,
   input  wire logic              cas_n,
   input  wire logic              we_n,
   input  wire logic [1:0]        ba,
   input  wire logic [ROW_W-1:0]  addr,
   // Data pins
   input  wire logic              dqm,
   input  wire logic [DATA_W-1:0] dq_in,
   output logic      [DATA_W-1:0] dq_out,
   output logic                   dq_oe,
   // Storage array port, read data returned in the same cycle
   output logic                   arr_re,
   output logic                   arr_we,
   output logic      [1:0]        arr_bank,
   output logic      [ROW_W-1:0]  arr_row,
   output logic      [COL_W-1:0]  arr_col,
   output logic      [DATA_W-1:0] arr_wdata,
   input  wire logic [DATA_W-1:0] arr_rdata,
   // Status
   output logic      [3:0]        bank_busy
);
   //==========================================================================
   // Burst length code to last offset; unknown codes act as one
   function automatic logic [COL_W-1:0] bl_last(input logic [2:0] code);
      unique case (code)
         3'h1:                bl_last = COL_W'(1);
         3'h2:                bl_last = COL_W'(3);
         3'h3:                bl_last = COL_W'(7);
         sdcap_pkg::BL_FULL:  bl_last = '1;
         default:             bl_last = '0;
      endcase
   endfunction

   // Column of element off within the burst block
   function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
      input logic [COL_W-1:0] off, input logic [COL_W-1:0] msk, input logic ilv);
      burst_col = (start & ~msk) | ((ilv ? (start ^ off) : (start + off)) & msk);
   endfunction

   //==========================================================================
   // Registers
   logic [2:0]          mr_bl_reg,    mr_bl_next;
   logic                mr_seq_reg,   mr_seq_next;
   logic [2:0]          mr_cl_reg,    mr_cl_next;
   logic                wbm_reg,      wbm_next;
   sdcap_pkg::sdcap_burst_t bkind_reg, bkind_next;
   logic [1:0]          bbank_reg,    bbank_next;
   logic [COL_W-1:0]    bstart_reg,   bstart_next;
   logic [COL_W-1:0]    boff_reg,     boff_next;
   logic [COL_W-1:0]    blast_reg,    blast_next;
   logic                are_reg,      are_next;
   logic                awe_reg,      awe_next;
   logic [1:0]          abank_reg,    abank_next;
   logic [ROW_W-1:0]    arow_reg,     arow_next;
   logic [COL_W-1:0]    acol_reg,     acol_next;
   logic [DATA_W-1:0]   awdata_reg,   awdata_next;
   logic                p1_vld_reg,   p1_vld_next;
   logic [DATA_W-1:0]   p1_data_reg,  p1_data_next;
   logic                dqm_d1_reg;
   logic [DATA_W-1:0]   dq_out_reg,   dq_out_next;
   logic                dq_oe_reg,    dq_oe_next;
   logic [3:0]          busy_reg;

   // Decode and per-bank wiring
   logic [2:0]          cmd;
   logic                acc_rd, acc_wr, cmd_bst, cmd_lmr, cmd_act, cmd_pre;
   logic [3:0]          open_vec, busy_vec, act_vec, pre_vec, arm_vec, endr_vec, endw_vec;
   logic [ROW_W-1:0]    row_vec [4];
   logic                do_elem;
   logic [1:0]          el_bank;
   logic [COL_W-1:0]    el_col;

   assign cmd     = {ras_n, cas_n, we_n};
   // Accesses to another bank during auto precharge are taken like any other
   assign acc_rd  = !cs_n && cmd == sdcap_pkg::CMD_RD && open_vec[ba]; // RULE4
   assign acc_wr  = !cs_n && cmd == sdcap_pkg::CMD_WR && open_vec[ba]; // RULE4
   assign cmd_bst = !cs_n && cmd == sdcap_pkg::CMD_BST;
   assign cmd_lmr = !cs_n && cmd == sdcap_pkg::CMD_LMR && bkind_reg == sdcap_pkg::BURST_IDLE;
   assign cmd_act = !cs_n && cmd == sdcap_pkg::CMD_ACT;
   assign cmd_pre = !cs_n && cmd == sdcap_pkg::CMD_PRE;

   //==========================================================================
   // Bank trackers
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_bank
         sdcap_bank_if #(.ROW_W(ROW_W)) bk_if ();
         assign bk_if.activate  = act_vec[g];
         assign bk_if.precharge = pre_vec[g];
         assign bk_if.arm_ap    = arm_vec[g];
         assign bk_if.end_rd    = endr_vec[g];
         assign bk_if.end_wr    = endw_vec[g];
         assign bk_if.row_in    = addr;
         assign open_vec[g]     = bk_if.is_open;
         assign busy_vec[g]     = bk_if.busy;
         assign row_vec[g]      = bk_if.row;
         sdcap_bank u_bank (
            .clk_sys (clk_sys),
            .reset_n (reset_n),
            .bk      (bk_if.bank)
         );
      end
   endgenerate

   //==========================================================================
   // Mode register; the write burst mode bit picks single writes
   always_comb begin
      mr_bl_next  = mr_bl_reg;
      mr_seq_next = mr_seq_reg;
      mr_cl_next  = mr_cl_reg;
      wbm_next    = wbm_reg;
      if (cmd_lmr) begin
         mr_bl_next  = addr[sdcap_pkg::MR_BL_LSB +: 3];
         mr_seq_next = addr[sdcap_pkg::MR_SEQ_BIT];
         mr_cl_next  = addr[sdcap_pkg::MR_CL_LSB +: 3];
         wbm_next    = addr[sdcap_pkg::MR_WBM_BIT]; // RULE1
      end
   end

   //==========================================================================
   // Burst engine: a new access ends whatever burst is running, on any bank
   always_comb begin
      bkind_next  = bkind_reg;
      bbank_next  = bbank_reg;
      bstart_next = bstart_reg;
      boff_next   = boff_reg;
      blast_next  = blast_reg;
      act_vec     = 4'h0;
      pre_vec     = 4'h0;
      arm_vec     = 4'h0;
      endr_vec    = 4'h0;
      endw_vec    = 4'h0;
      do_elem     = 1'b0;
      el_bank     = bbank_reg;
      el_col      = burst_col(bstart_reg, boff_reg, blast_reg, mr_seq_reg);
      if (cmd_act) begin
         act_vec[ba] = 1'b1;
      end
      if (cmd_pre) begin
         pre_vec = addr[sdcap_pkg::AP_BIT] ? 4'hF : 4'h0;
         pre_vec[ba] = 1'b1;
      end
      if (acc_rd || acc_wr || cmd_bst) begin
         // Interruption: old bank sees its burst end at this registration
         endr_vec[bbank_reg] = (bkind_reg == sdcap_pkg::BURST_RD); // RULE6 RULE7
         endw_vec[bbank_reg] = (bkind_reg == sdcap_pkg::BURST_WR); // RULE10 RULE12
         bkind_next = sdcap_pkg::BURST_IDLE;
      end
      if (acc_rd || acc_wr) begin
         arm_vec[ba] = addr[sdcap_pkg::AP_BIT];
         bbank_next  = ba;
         bstart_next = addr[COL_W-1:0];
         // Reads always follow the programmed length; writes too unless single
         blast_next  = (acc_wr && wbm_reg) ? '0 : bl_last(mr_bl_reg); // RULE2 RULE3
         boff_next   = COL_W'(1);
         do_elem     = 1'b1;
         el_bank     = ba;
         el_col      = addr[COL_W-1:0];
         if (blast_next == '0) begin
            endr_vec[ba] = acc_rd; // RULE14
            endw_vec[ba] = acc_wr; // RULE14
         end else begin
            bkind_next = acc_rd ? sdcap_pkg::BURST_RD : sdcap_pkg::BURST_WR;
         end
      end else if (!cmd_bst && bkind_reg != sdcap_pkg::BURST_IDLE) begin
         do_elem   = 1'b1;
         boff_next = boff_reg + COL_W'(1);
         // Full page never ends by itself; it wraps until cut
         if (boff_reg == blast_reg && mr_bl_reg != sdcap_pkg::BL_FULL) begin
            bkind_next = sdcap_pkg::BURST_IDLE;
            endr_vec[bbank_reg] = (bkind_reg == sdcap_pkg::BURST_RD); // RULE14
            endw_vec[bbank_reg] = (bkind_reg == sdcap_pkg::BURST_WR); // RULE14
         end
      end
   end

   //==========================================================================
   // Array access and read data path; a WRITE flushes read data in flight
   always_comb begin
      logic is_rd;
      is_rd       = acc_rd || (!acc_wr && bkind_reg == sdcap_pkg::BURST_RD);
      are_next    = do_elem && is_rd;
      // Only data registered up to the cycle before a READ is stored
      awe_next    = do_elem && !is_rd && !dqm; // RULE11 RULE13
      abank_next  = el_bank;
      arow_next   = row_vec[el_bank];
      acol_next   = el_col;
      awdata_next = dq_in;
      p1_vld_next  = are_reg && !acc_wr; // RULE7
      p1_data_next = arr_rdata;
      // CAS latency two skips the extra stage
      if (mr_cl_reg == 3'h2) begin
         dq_out_next = arr_rdata;
         dq_oe_next  = are_reg && !acc_wr && !dqm_d1_reg; // RULE5 RULE9
      end else begin
         dq_out_next = p1_data_reg;
         dq_oe_next  = p1_vld_reg && !acc_wr && !dqm_d1_reg; // RULE5 RULE9
      end
   end

   //==========================================================================
   // Registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mr_bl_reg   <= sdcap_pkg::MR_BL_RST;
         mr_seq_reg  <= 1'b0;
         mr_cl_reg   <= sdcap_pkg::MR_CL_RST;
         wbm_reg     <= 1'b0;
         bkind_reg   <= sdcap_pkg::BURST_IDLE;
         bbank_reg   <= 2'h0;
         bstart_reg  <= '0;
         boff_reg    <= '0;
         blast_reg   <= '0;
         are_reg     <= 1'b0;
         awe_reg     <= 1'b0;
         abank_reg   <= 2'h0;
         arow_reg    <= '0;
         acol_reg    <= '0;
         awdata_reg  <= '0;
         p1_vld_reg  <= 1'b0;
         p1_data_reg <= '0;
         dqm_d1_reg  <= 1'b0;
         dq_out_reg  <= '0;
         dq_oe_reg   <= 1'b0;
         busy_reg    <= 4'h0;
      end else begin
         mr_bl_reg   <= mr_bl_next;
         mr_seq_reg  <= mr_seq_next;
         mr_cl_reg   <= mr_cl_next;
         wbm_reg     <= wbm_next;
         bkind_reg   <= bkind_next;
         bbank_reg   <= bbank_next;
         bstart_reg  <= bstart_next;
         boff_reg    <= boff_next;
         blast_reg   <= blast_next;
         are_reg     <= are_next;
         awe_reg     <= awe_next;
         abank_reg   <= abank_next;
         arow_reg    <= arow_next;
         acol_reg    <= acol_next;
         awdata_reg  <= awdata_next;
         p1_vld_reg  <= p1_vld_next;
         p1_data_reg <= p1_data_next;
         dqm_d1_reg  <= dqm;
         dq_out_reg  <= dq_out_next;
         dq_oe_reg   <= dq_oe_next;
         busy_reg    <= busy_vec;
      end
   end

   assign dq_out    = dq_out_reg;
   assign dq_oe     = dq_oe_reg;
   assign arr_re    = are_reg;
   assign arr_we    = awe_reg;
   assign arr_bank  = abank_reg;
   assign arr_row   = arow_reg;
   assign arr_col   = acol_reg;
   assign arr_wdata = awdata_reg;
   assign bank_busy = busy_reg;

   //==========================================================================
   // Checks
   a_wbm_load: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE1
      cmd_lmr |=> wbm_reg == $past(addr[sdcap_pkg::MR_WBM_BIT]))
      else $error("write burst mode bit not loaded");
   a_single_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE2
      (acc_wr && wbm_reg) |=> bkind_reg == sdcap_pkg::BURST_IDLE)
      else $error("single write mode wrote more than one element");
   a_read_len_four: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE3
      (acc_rd && mr_bl_reg == 3'h2) |=> bkind_reg == sdcap_pkg::BURST_RD && blast_reg == COL_W'(3))
      else $error("read burst length not followed");
   a_read_switch: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE5
      acc_rd |=> arr_re && arr_bank == $past(ba))
      else $error("interrupting read not issued next cycle");
   a_write_cut_rd: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE7
      acc_wr |=> !dq_oe && !arr_re)
      else $error("read data still driven after write");
   a_read_cl_two: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE9
      (acc_rd && mr_cl_reg == 3'h2 && !dqm) ##1 !acc_wr |=> dq_oe)
      else $error("read data not out at cas latency two");
   a_last_wr_elem: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE11
      acc_rd |=> !arr_we)
      else $error("write data stored after read registered");
   a_new_wr_bank: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE13
      (acc_wr && !dqm) |=> arr_we && arr_bank == $past(ba) && arr_wdata == $past(dq_in))
      else $error("interrupting write data not routed to new bank");
endmodule // sdcap_core

// *** test/sdcap_arr_model.sv ***
// Storage array model answering the column engine in the same cycle
`timescale 1ns/1ns
module sdcap_arr_model (
   // Clock
   input  wire logic        clk_sys,
   // Array port from the column engine
   input  wire logic        arr_re,
   input  wire logic        arr_we,
   input  wire logic [1:0]  arr_bank,
   input  wire logic [7:0]  arr_col,
   input  wire logic [15:0] arr_wdata,
   output logic      [15:0] arr_rdata
);
   //===========================================================================
   // Storage, indexed by bank and column; the row is not modelled
   logic [15:0] mem [0:1023];
   initial begin
      for (int i = 0; i < 1024; i++) mem[i] = 16'(i) ^ 16'h5a5a;
   end
   // Outside a read the port shows the inverse, so a stray sample cannot pass
   assign arr_rdata = arr_re ? mem[{arr_bank, arr_col}] : ~mem[{arr_bank, arr_col}];
   always_ff @(posedge clk_sys) begin
      if (arr_we) mem[{arr_bank, arr_col}] <= arr_wdata;
   end
endmodule // sdcap_arr_model

// *** test/tb.sv ***
// Self-checking bench for the column engine and concurrent auto precharge
`timescale 1ns/1ns
module tb;
   localparam logic [2:0]  NOP = 3'h7;
   localparam logic [11:0] AP  = 12'h400;
   logic clk_sys = 1'b0, reset_n = 1'b0, cs_n = 1'b0, ras_n = 1'b1, cas_n = 1'b1, we_n = 1'b1;
   logic dqm = 1'b0, dq_oe, arr_re, arr_we;
   logic [1:0]  ba = 2'h0, arr_bank;
   logic [11:0] addr = 12'h000, arr_row;
   logic [15:0] dq_in = 16'h0000, dq_out, arr_wdata, arr_rdata;
   logic [7:0]  arr_col;
   logic [3:0]  bank_busy;
   int error_cnt = 0, n_tests = 0, nrd = 0;
   int nwe [4], nre [4];
   logic [15:0] lastrd;
   logic [15:0] lastwd [4];
   logic [7:0]  lastcol [4];
   //===========================================================================
   // Clock and devices
   always #25 clk_sys = ~clk_sys;
   sdcap_core u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .arr_re(arr_re), .arr_we(arr_we), .arr_bank(arr_bank),
      .arr_row(arr_row), .arr_col(arr_col), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata),
      .bank_busy(bank_busy));
   sdcap_arr_model u_arr (.clk_sys(clk_sys), .arr_re(arr_re), .arr_we(arr_we),
      .arr_bank(arr_bank), .arr_col(arr_col), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata));
   // Element monitor; samples the registered outputs of the previous cycle
   always @(posedge clk_sys) begin
      if (arr_we === 1'b1) begin
         nwe[arr_bank]++;
         lastwd[arr_bank] = arr_wdata;
      end
      if (arr_re === 1'b1) begin
         nre[arr_bank]++;
         lastcol[arr_bank] = arr_col;
      end
      if (dq_oe === 1'b1) begin
         nrd++;
         lastrd = dq_out;
      end
   end
   //===========================================================================
   // Shared tasks
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
                      input logic [15:0] d, input logic m);
      @(posedge clk_sys);
      {ras_n, cas_n, we_n} <= c;
      ba <= b;
      addr <= a;
      dq_in <= d;
      dqm <= m;
   endtask
   task automatic idle(input int n);
      repeat (n) cmd(NOP, 2'h0, 12'h000, 16'h0000, 1'b0);
   endtask
   task automatic clr();
      #1;
      nrd = 0;
      foreach (nwe[i]) begin
         nwe[i] = 0;
         nre[i] = 0;
      end
   endtask
   // Bank must be idle again within a bound counted from the last command
   task automatic wait_idle(input int b, input int bound);
      for (int i = 0; i < bound; i++) begin
         idle(1);
         #1;
         if (bank_busy[b] === 1'b0) return;
      end
      error_cnt++;
      $display("BAD bank %0d idle expected 0 seen %b", b, bank_busy[b]);
      stop_test();
   endtask
   task automatic mode(input logic [2:0] bl, input logic wbm);
      cmd(sdcap_pkg::CMD_LMR, 2'h0, (12'(wbm) << 9) | 12'h020 | 12'(bl), 16'h0000, 1'b0);
      idle(1);
   endtask
   //===========================================================================
   // Scenarios
   task automatic t_single_write();
      mode(3'h1, 1'b1);
      cmd(sdcap_pkg::CMD_ACT, 2'h0, 12'h000, 16'h0000, 1'b0);
      clr();
      cmd(sdcap_pkg::CMD_WR, 2'h0, 12'h004, 16'h1111, 1'b0);
      cmd(NOP, 2'h0, 12'h000, 16'h2222, 1'b0);
      idle(4);
      chk("single write count", 16'(1), 16'(nwe[0]));
      chk("single write data", 16'h1111, lastwd[0]);
      clr();
      cmd(sdcap_pkg::CMD_RD, 2'h0, 12'h004, 16'h0000, 1'b0);
      idle(5);
      chk("read burst count", 16'(2), 16'(nre[0]));
      chk("read last column", 16'h0005, 16'(lastcol[0]));
      chk("read data count", 16'(2), 16'(nrd));
      chk("read burst data", 16'h5a5f, lastrd);
      // Length four, interleaved, latency three: columns 5 4 7 6
      cmd(sdcap_pkg::CMD_LMR, 2'h0, 12'h03A, 16'h0000, 1'b0);
      idle(1);
      clr();
      cmd(sdcap_pkg::CMD_RD, 2'h0, 12'h005, 16'h0000, 1'b0);
      idle(8);
      chk("interleaved last column", 16'h0006, 16'(lastcol[0]));
      chk("interleaved data count", 16'(4), 16'(nrd));
      chk("interleaved read data", 16'h5a5c, lastrd);
   endtask
   task automatic t_rd_rd();
      mode(3'h2, 1'b0);
      cmd(sdcap_pkg::CMD_ACT, 2'h1, 12'h000, 16'h0000, 1'b0);
      cmd(sdcap_pkg::CMD_ACT, 2'h2, 12'h000, 16'h0000, 1'b0);
      clr();
      cmd(sdcap_pkg::CMD_RD, 2'h1, AP, 16'h0000, 1'b0);
      cmd(sdcap_pkg::CMD_RD, 2'h2, 12'h000, 16'h0000, 1'b0);
      wait_idle(1, 4);
      idle(6);
      chk("cut read elements", 16'(1), 16'(nre[1]));
      chk("new read elements", 16'(4), 16'(nre[2]));
      chk("read data total", 16'(5), 16'(nrd));
   endtask
   task automatic t_rd_wr();
      cmd(sdcap_pkg::CMD_ACT, 2'h1, 12'h000, 16'h0000, 1'b0);
      clr();
      cmd(sdcap_pkg::CMD_RD, 2'h1, AP, 16'h0000, 1'b0);
      cmd(NOP, 2'h0, 12'h000, 16'h0000, 1'b1);
      cmd(NOP, 2'h0, 12'h000, 16'h0000, 1'b1);
      cmd(sdcap_pkg::CMD_WR, 2'h2, 12'h010, 16'h3333, 1'b0);
      wait_idle(1, 4);
      idle(6);
      chk("read data before write", 16'(1), 16'(nrd));
      chk("writes to new bank", 16'(4), 16'(nwe[2]));
   endtask
   task automatic t_wr_rd();
      cmd(sdcap_pkg::CMD_ACT, 2'h1, 12'h000, 16'h0000, 1'b0);
      clr();
      cmd(sdcap_pkg::CMD_WR, 2'h1, AP, 16'haaaa, 1'b0);
      cmd(NOP, 2'h0, 12'h000, 16'hbbbb, 1'b0);
      cmd(sdcap_pkg::CMD_RD, 2'h2, 12'h000, 16'hcccc, 1'b0);
      wait_idle(1, 5);
      idle(5);
      chk("kept write count", 16'(2), 16'(nwe[1]));
      chk("last kept write", 16'hbbbb, lastwd[1]);
      chk("read after write", 16'(4), 16'(nrd));
   endtask
   task automatic t_wr_wr();
      cmd(sdcap_pkg::CMD_ACT, 2'h1, 12'h000, 16'h0000, 1'b0);
      clr();
      cmd(sdcap_pkg::CMD_WR, 2'h1, AP, 16'hd00d, 1'b0);
      cmd(sdcap_pkg::CMD_WR, 2'h2, 12'h020, 16'he00e, 1'b0);
      wait_idle(1, 5);
      idle(4);
      chk("kept write count", 16'(1), 16'(nwe[1]));
      chk("last kept write", 16'hd00d, lastwd[1]);
      chk("new bank writes", 16'(4), 16'(nwe[2]));
   endtask
   //===========================================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      chk("reset dq_oe", 16'h0000, 16'(dq_oe));
      reset_n <= 1'b1;
      t_single_write();
      t_rd_rd();
      t_rd_wr();
      t_wr_rd();
      t_wr_wr();
      stop_test();
   end
endmodule // tb
